// >>> hdl/trq_engine.sv
// Transient read engine of the master module: validates a control block, fetches words from a
// remote station over the field network and reports completion on the program scan
// Assumes the network port is same-clock logic; LINK_UP comes from outside and is synchronised
//
// Overview of operation
// - Status word: zero if good, else error
// - Requester gives station number 0 to 64
// - Access code high byte, attribute low byte
// - Start address; random buffer counts from zero
// - Requester gives word count 1 to 480
// - Older controller devices: count 1 to 32
// - Buffer memories: attribute 04, listed access codes
// - Controller devices: attribute 05, per-type codes
// - Refuse any access code not listed
// - Bit device start: zero or multiple of 16
// - Link down: no error, never completes
// - Completion flag high exactly one scan
// - Abnormal end also raises error flag
// - Requester names module by I/O base
// - Read buffer memory or controller devices
// - Normal end keeps error flag low
//
// Strobed register access and the register offsets were chosen for this implementation.
`timescale 1ns/100ps
module trq_engine #(
    parameter logic [15:0] IO_BASE = 16'h0000
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    trq_if.engine LINK,
    input wire logic LINK_UP,
    output logic NET_REQ,
    output logic [6:0] NET_STATION,
    output logic [7:0] NET_ACCESS,
    output logic [7:0] NET_ATTR,
    output logic [15:0] NET_ADDR,
    output logic [15:0] NET_COUNT,
    input wire logic NET_RVALID,
    input wire logic [15:0] NET_RDATA,
    input wire logic NET_DONE,
    input wire logic NET_FAIL,
    output logic BUSY
);
    trq_pkg::trq_state_e state;
    trq_pkg::trq_state_e next_state;
    logic [6:0] station;
    logic [6:0] next_station;
    logic [15:0] codes;
    logic [15:0] next_codes;
    logic [15:0] start_addr;
    logic [15:0] next_start_addr;
    logic [15:0] count;
    logic [15:0] next_count;
    logic [8:0] idx;
    logic [8:0] next_idx;
    logic [15:0] err;
    logic [15:0] next_err;
    logic data_we;
    logic next_data_we;
    logic [8:0] data_idx;
    logic [8:0] next_data_idx;
    logic [15:0] data_word;
    logic [15:0] next_data_word;
    logic status_we;
    logic next_status_we;
    logic [15:0] status_code;
    logic [15:0] next_status_code;
    logic done;
    logic next_done;
    logic done_err;
    logic next_done_err;
    logic net_req;
    logic next_net_req;
    logic busy;
    logic next_busy;
    logic link_meta;
    logic link_up;
    logic [15:0] chk_err;
    logic store;
    logic [8:0] got;

    trq_code_check u_check (
        .codes(codes),
        .station(station),
        .start_addr(start_addr),
        .count(count),
        .err_code(chk_err)
    );

    assign LINK.data_we = data_we;
    assign LINK.data_idx = data_idx;
    assign LINK.data_word = data_word;
    assign LINK.status_we = status_we;
    assign LINK.status_code = status_code;
    assign LINK.done = done;
    assign LINK.done_err = done_err;
    assign LINK.busy = busy;
    assign NET_REQ = net_req;
    assign NET_STATION = station;
    assign NET_ACCESS = codes[trq_pkg::ACCESS_LSB +: 8];
    assign NET_ATTR = codes[trq_pkg::ATTR_LSB +: 8];
    assign NET_ADDR = start_addr;
    assign NET_COUNT = count;
    assign BUSY = busy;

    // Words beyond the requested count are dropped
    assign store = NET_RVALID && ({7'h00, idx} < count);
    assign got = store ? idx + 9'h001 : idx;

    always_comb
    begin
        next_state = state;
        next_station = station;
        next_codes = codes;
        next_start_addr = start_addr;
        next_count = count;
        next_idx = idx;
        next_err = err;
        next_data_we = 1'b0;
        next_data_idx = data_idx;
        next_data_word = data_word;
        next_status_we = 1'b0;
        next_status_code = status_code;
        next_done = done;
        next_done_err = done_err;
        next_net_req = 1'b0;
        next_busy = busy;
        unique case (state)
            trq_pkg::ST_IDLE:
            begin
                if (LINK.start && (LINK.io_base == IO_BASE))
                begin
                    next_station = LINK.station;
                    next_codes = LINK.codes;
                    next_start_addr = LINK.start_addr;
                    next_count = LINK.count;
                    next_busy = 1'b1;
                    next_state = trq_pkg::ST_CHECK;
                end
            end
            trq_pkg::ST_CHECK:
            begin
                if (chk_err != trq_pkg::ERR_NONE)
                begin
                    next_err = chk_err;
                    next_status_we = 1'b1;
                    next_status_code = chk_err;
                    next_state = trq_pkg::ST_REPORT;
                end
                else if (!link_up)
                begin
                    next_state = trq_pkg::ST_HANG;
                end
                else
                begin
                    next_net_req = 1'b1;
                    next_idx = 9'h000;
                    next_state = trq_pkg::ST_FETCH;
                end
            end
            trq_pkg::ST_HANG:
            begin
                // Only the requester can release an offline request
                if (LINK.cancel)
                begin
                    next_busy = 1'b0;
                    next_state = trq_pkg::ST_IDLE;
                end
            end
            trq_pkg::ST_FETCH:
            begin
                if (store)
                begin
                    next_data_we = 1'b1;
                    next_data_idx = idx;
                    next_data_word = NET_RDATA;
                    next_idx = got;
                end
                if (NET_DONE)
                begin
                    if (NET_FAIL || ({7'h00, got} != count))
                        next_err = trq_pkg::ERR_REMOTE;
                    else
                        next_err = trq_pkg::ERR_NONE;
                    next_status_we = 1'b1;
                    next_status_code = next_err;
                    next_state = trq_pkg::ST_REPORT;
                end
            end
            trq_pkg::ST_REPORT:
            begin
                if (LINK.scan_end)
                begin
                    next_done = 1'b1;
                    next_done_err = (err != trq_pkg::ERR_NONE);
                    next_state = trq_pkg::ST_HOLD;
                end
            end
            trq_pkg::ST_HOLD:
            begin
                if (LINK.scan_end)
                begin
                    next_done = 1'b0;
                    next_done_err = 1'b0;
                    next_busy = 1'b0;
                    next_state = trq_pkg::ST_IDLE;
                end
            end
            default:
            begin
                next_busy = 1'b0;
                next_done = 1'b0;
                next_done_err = 1'b0;
                next_state = trq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            link_meta <= 1'b0;
            link_up <= 1'b0;
        end
        else
        begin
            link_meta <= LINK_UP;
            link_up <= link_meta;
        end
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            state <= trq_pkg::ST_IDLE;
            station <= 7'h00;
            codes <= 16'h0000;
            start_addr <= 16'h0000;
            count <= 16'h0000;
            idx <= 9'h000;
            err <= 16'h0000;
            data_we <= 1'b0;
            data_idx <= 9'h000;
            data_word <= 16'h0000;
            status_we <= 1'b0;
            status_code <= 16'h0000;
            done <= 1'b0;
            done_err <= 1'b0;
            net_req <= 1'b0;
            busy <= 1'b0;
        end
        else
        begin
            state <= next_state;
            station <= next_station;
            codes <= next_codes;
            start_addr <= next_start_addr;
            count <= next_count;
            idx <= next_idx;
            err <= next_err;
            data_we <= next_data_we;
            data_idx <= next_data_idx;
            data_word <= next_data_word;
            status_we <= next_status_we;
            status_code <= next_status_code;
            done <= next_done;
            done_err <= next_done_err;
            net_req <= next_net_req;
            busy <= next_busy;
        end
    end
endmodule

// >>> hdl/trq_pkg.sv
// Constants, codes and state types shared by the transient read engine and its requester
// Assumes both ends run on one 100 MHz core clock
package trq_pkg;
    localparam int CLK_PERIOD_NS = 10;
    localparam int SCAN_TIME_NS = 10000;
    localparam int SCAN_CYCLES = SCAN_TIME_NS / CLK_PERIOD_NS;
    localparam int WORD_W = 16;
    localparam int IDX_W = 9;
    localparam int DEPTH = 480;
    localparam logic [6:0] STATION_MAX = 7'h40;
    localparam logic [15:0] COUNT_MIN = 16'h0001;
    localparam logic [15:0] COUNT_MAX = 16'h01E0;
    localparam logic [15:0] COUNT_MAX_LEGACY = 16'h0020;
    localparam logic [15:0] IO_BASE_MAX = 16'h00FE;
    localparam logic [3:0] BIT_ALIGN_MASK = 4'hF;
    localparam int ACCESS_LSB = 8;
    localparam int ATTR_LSB = 0;
    localparam logic [7:0] ATTR_BUFFER = 8'h04;
    localparam logic [7:0] ATTR_DEVICE = 8'h05;
    // Buffer memory: device buffer, random access, remote in/out/register, link relay/register
    localparam logic [7:0] BUF_CODES [7] = '{8'h00, 8'h20, 8'h21, 8'h22, 8'h24, 8'h63, 8'h64};
    // Controller bit devices
    localparam logic [7:0] DEV_BIT_CODES [13] = '{8'h01, 8'h02, 8'h03, 8'h83, 8'h23, 8'h09, 8'h0A,
        8'h89, 8'h8A, 8'h11, 8'h12, 8'h63, 8'h43};
    // Controller word devices
    localparam logic [7:0] DEV_WORD_CODES [8] = '{8'h0C, 8'h8C, 8'h14, 8'h04, 8'h24, 8'h84, 8'h64, 8'h44};
    localparam logic [15:0] ERR_NONE = 16'h0000;
    localparam logic [15:0] ERR_ACCESS = 16'h0011;
    localparam logic [15:0] ERR_STATION = 16'h0012;
    localparam logic [15:0] ERR_COUNT = 16'h0013;
    localparam logic [15:0] ERR_ALIGN = 16'h0014;
    localparam logic [15:0] ERR_REMOTE = 16'h0015;
    localparam logic [9:0] REG_CTRL = 10'h000;
    localparam logic [9:0] REG_STATION = 10'h001;
    localparam logic [9:0] REG_CODES = 10'h002;
    localparam logic [9:0] REG_START = 10'h003;
    localparam logic [9:0] REG_COUNT = 10'h004;
    localparam logic [9:0] REG_STATUS = 10'h005;
    localparam logic [9:0] REG_FLAGS = 10'h006;
    localparam logic [9:0] REG_IRQ_STAT = 10'h007;
    localparam logic [9:0] REG_IRQ_CLR = 10'h008;
    localparam logic [9:0] REG_IRQ_EN = 10'h009;
    localparam int DATA_WINDOW_BIT = 9;
    localparam int CTRL_GO_BIT = 0;
    localparam int CTRL_CANCEL_BIT = 1;
    localparam int IRQ_OK_BIT = 0;
    localparam int IRQ_FAIL_BIT = 1;
    localparam int IRQ_REJECT_BIT = 2;
    localparam int IRQ_W = 3;
    typedef enum logic [5:0] {
        ST_IDLE = 6'b000001,
        ST_CHECK = 6'b000010,
        ST_HANG = 6'b000100,
        ST_FETCH = 6'b001000,
        ST_REPORT = 6'b010000,
        ST_HOLD = 6'b100000
    } trq_state_e;
endpackage

// >>> hdl/trq_if.sv
// Control block link between the requesting controller and the read engine
// Assumes both modports sit on the same core clock
`timescale 1ns/100ps
interface trq_if;
    logic start;
    logic cancel;
    logic [15:0] io_base;
    logic [6:0] station;
    logic [15:0] codes;
    logic [15:0] start_addr;
    logic [15:0] count;
    logic scan_end;
    logic data_we;
    logic [8:0] data_idx;
    logic [15:0] data_word;
    logic status_we;
    logic [15:0] status_code;
    logic done;
    logic done_err;
    logic busy;
    modport engine (
        input start, cancel, io_base, station, codes, start_addr, count, scan_end,
        output data_we, data_idx, data_word, status_we, status_code, done, done_err, busy
    );
    modport requester (
        output start, cancel, io_base, station, codes, start_addr, count, scan_end,
        input data_we, data_idx, data_word, status_we, status_code, done, done_err, busy
    );
endinterface

// >>> hdl/trq_code_check.sv
// Combinational check of a control block: access and attribute codes, station, count, alignment
// Assumes inputs are stable register values
`timescale 1ns/100ps
module trq_code_check (
    input wire logic [15:0] codes,
    input wire logic [6:0] station,
    input wire logic [15:0] start_addr,
    input wire logic [15:0] count,
    output logic [15:0] err_code
);
    logic [7:0] acc;
    logic [7:0] attr;
    logic buf_hit;
    logic bit_hit;
    logic word_hit;
    logic code_ok;

    assign acc = codes[trq_pkg::ACCESS_LSB +: 8];
    assign attr = codes[trq_pkg::ATTR_LSB +: 8];

    always_comb
    begin
        buf_hit = 1'b0;
        bit_hit = 1'b0;
        word_hit = 1'b0;
        for (int i = 0; i < 7; i++)
        begin
            buf_hit = buf_hit | (acc == trq_pkg::BUF_CODES[i]);
        end
        for (int i = 0; i < 13; i++)
        begin
            bit_hit = bit_hit | (acc == trq_pkg::DEV_BIT_CODES[i]);
        end
        for (int i = 0; i < 8; i++)
        begin
            word_hit = word_hit | (acc == trq_pkg::DEV_WORD_CODES[i]);
        end
        code_ok = ((attr == trq_pkg::ATTR_BUFFER) && buf_hit) ||
            ((attr == trq_pkg::ATTR_DEVICE) && (bit_hit || word_hit));
        if (!code_ok)
            err_code = trq_pkg::ERR_ACCESS;
        else if (station > trq_pkg::STATION_MAX)
            err_code = trq_pkg::ERR_STATION;
        else if ((count < trq_pkg::COUNT_MIN) || (count > trq_pkg::COUNT_MAX))
            err_code = trq_pkg::ERR_COUNT;
        else if ((attr == trq_pkg::ATTR_DEVICE) && bit_hit && ((start_addr[3:0] & trq_pkg::BIT_ALIGN_MASK) != 4'h0))
            err_code = trq_pkg::ERR_ALIGN;
        else
            err_code = trq_pkg::ERR_NONE;
    end
endmodule

// >>> hdl/trq_requester.sv
// Requesting controller: software register port, control block, scan pacing, read data store, interrupt
// Assumes the engine sits on the same core clock across trq_if
`timescale 1ns/100ps
module trq_requester #(
    parameter logic [15:0] IO_BASE = 16'h0000,
    parameter int SCAN_CYCLES = trq_pkg::SCAN_CYCLES,
    parameter int DEPTH = trq_pkg::DEPTH,
    parameter logic LEGACY_TARGET = 1'b0
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    trq_if.requester LINK,
    input wire logic [9:0] ADDR,
    input wire logic [15:0] WR_DATA,
    input wire logic WR,
    input wire logic RD,
    output logic [15:0] RD_DATA,
    output logic IRQ
);
    logic [15:0] mem [DEPTH];
    logic [6:0] station, next_station;
    logic [15:0] codes, next_codes;
    logic [15:0] start_addr, next_start_addr;
    logic [15:0] count, next_count;
    logic [15:0] status, next_status;
    logic [2:0] irq_stat, next_irq_stat;
    logic [2:0] irq_en, next_irq_en;
    logic start, next_start;
    logic cancel, next_cancel;
    logic pending, next_pending;
    logic done_q;
    logic [31:0] scan_cnt, next_scan_cnt;
    logic scan_end, next_scan_end;
    logic [15:0] rd_data, next_rd_data;
    logic irq, next_irq;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [15:0] chk_err;
    logic legacy_bad;

    trq_code_check u_check (
        .codes(codes),
        .station(station),
        .start_addr(start_addr),
        .count(count),
        .err_code(chk_err)
    );

    assign LINK.start = start;
    assign LINK.cancel = cancel;
    assign LINK.io_base = IO_BASE;
    assign LINK.station = station;
    assign LINK.codes = codes;
    assign LINK.start_addr = start_addr;
    assign LINK.count = count;
    assign LINK.scan_end = scan_end;
    assign RD_DATA = rd_data;
    assign IRQ = irq;
    assign legacy_bad = LEGACY_TARGET && (codes[trq_pkg::ATTR_LSB +: 8] == trq_pkg::ATTR_DEVICE) &&
        (count > trq_pkg::COUNT_MAX_LEGACY);

    always_comb
    begin
        next_station = station;
        next_codes = codes;
        next_start_addr = start_addr;
        next_count = count;
        next_status = status;
        next_irq_en = irq_en;
        next_start = 1'b0;
        next_cancel = 1'b0;
        next_pending = pending;
        next_rd_data = 16'h0000;
        ev = 3'h0;
        clr = 3'h0;
        next_scan_end = (scan_cnt == 32'(SCAN_CYCLES - 1));
        next_scan_cnt = next_scan_end ? 32'h0 : scan_cnt + 32'h1;
        if (WR)
        begin
            case (ADDR)
                trq_pkg::REG_CTRL:
                begin
                    if (WR_DATA[trq_pkg::CTRL_GO_BIT])
                    begin
                        if (!pending && !legacy_bad && (chk_err == trq_pkg::ERR_NONE))
                        begin
                            next_start = 1'b1;
                            next_pending = 1'b1;
                        end
                        else
                            ev[trq_pkg::IRQ_REJECT_BIT] = 1'b1;
                    end
                    if (WR_DATA[trq_pkg::CTRL_CANCEL_BIT])
                    begin
                        next_cancel = 1'b1;
                        next_pending = 1'b0;
                    end
                end
                trq_pkg::REG_STATION: next_station = WR_DATA[6:0];
                trq_pkg::REG_CODES: next_codes = WR_DATA;
                trq_pkg::REG_START: next_start_addr = WR_DATA;
                trq_pkg::REG_COUNT: next_count = WR_DATA;
                trq_pkg::REG_IRQ_CLR: clr = WR_DATA[2:0];
                trq_pkg::REG_IRQ_EN: next_irq_en = WR_DATA[2:0];
                default: next_irq_en = irq_en;
            endcase
        end
        if (LINK.status_we)
            next_status = LINK.status_code;
        if (LINK.done && !done_q)
        begin
            ev[trq_pkg::IRQ_OK_BIT] = !LINK.done_err;
            ev[trq_pkg::IRQ_FAIL_BIT] = LINK.done_err;
            next_pending = 1'b0;
        end
        next_irq_stat = (irq_stat & ~clr) | ev;
        next_irq = |(next_irq_stat & next_irq_en);
        if (RD)
        begin
            if (ADDR[trq_pkg::DATA_WINDOW_BIT])
                next_rd_data = (int'(ADDR[8:0]) < DEPTH) ? mem[ADDR[8:0]] : 16'h0000;
            else
            begin
                case (ADDR)
                    trq_pkg::REG_STATION: next_rd_data = {9'h000, station};
                    trq_pkg::REG_CODES: next_rd_data = codes;
                    trq_pkg::REG_START: next_rd_data = start_addr;
                    trq_pkg::REG_COUNT: next_rd_data = count;
                    trq_pkg::REG_STATUS: next_rd_data = status;
                    trq_pkg::REG_FLAGS: next_rd_data = {13'h0000, LINK.done_err, LINK.done, LINK.busy};
                    trq_pkg::REG_IRQ_STAT: next_rd_data = {13'h0000, irq_stat};
                    trq_pkg::REG_IRQ_EN: next_rd_data = {13'h0000, irq_en};
                    default: next_rd_data = 16'h0000;
                endcase
            end
        end
    end

    always_ff @(posedge CORE_CLK)
    begin
        if (LINK.data_we && (int'(LINK.data_idx) < DEPTH))
            mem[LINK.data_idx] <= LINK.data_word;
    end

    always_ff @(posedge CORE_CLK or negedge RESET_N)
    begin
        if (!RESET_N)
        begin
            station <= 7'h00;
            codes <= 16'h0000;
            start_addr <= 16'h0000;
            count <= 16'h0000;
            status <= 16'h0000;
            irq_stat <= 3'h0;
            irq_en <= 3'h0;
            start <= 1'b0;
            cancel <= 1'b0;
            pending <= 1'b0;
            done_q <= 1'b0;
            scan_cnt <= 32'h0;
            scan_end <= 1'b0;
            rd_data <= 16'h0000;
            irq <= 1'b0;
        end
        else
        begin
            station <= next_station;
            codes <= next_codes;
            start_addr <= next_start_addr;
            count <= next_count;
            status <= next_status;
            irq_stat <= next_irq_stat;
            irq_en <= next_irq_en;
            start <= next_start;
            cancel <= next_cancel;
            pending <= next_pending;
            done_q <= LINK.done;
            scan_cnt <= next_scan_cnt;
            scan_end <= next_scan_end;
            rd_data <= next_rd_data;
            irq <= next_irq;
        end
    end
endmodule

// >>> sim/trq_checker.sv
// Assertions on the trq_if signals between the requester and the engine
// Assumes one core clock and the active-low asynchronous reset
`timescale 1ns/100ps
module trq_checker #(
    parameter logic [15:0] IO_BASE = 16'h0000
) (
    input wire logic CORE_CLK,
    input wire logic RESET_N,
    input wire logic start,
    input wire logic [15:0] io_base,
    input wire logic scan_end,
    input wire logic done,
    input wire logic done_err,
    input wire logic busy
);
    default clocking cb @(posedge CORE_CLK);
    endclocking
    default disable iff (!RESET_N);
    err_needs_done_a: assert property (done_err |-> done) else $error("error flag without done");
    err_rise_a: assert property ($rose(done_err) |-> $rose(done)) else $error("error flag out of step");
    done_rise_a: assert property ($rose(done) |-> $past(scan_end)) else $error("done rose off scan end");
    done_hold_a: assert property (done && !scan_end |=> done) else $error("done dropped mid scan");
    done_drop_a: assert property (done && scan_end |=> !done) else $error("done held past a scan");
    ok_err_low_a: assert property (done && !done_err |=> !done_err) else $error("error flag moved");
    busy_with_done_a: assert property ($fell(done) |-> !busy) else $error("busy outlived done");
    start_take_a: assert property (start && !busy && io_base == IO_BASE |=> busy) else $error("start lost");
endmodule

// >>> sim/tb.sv
// Bench: requester and engine joined by trq_if; the remote station is played here
// Assumes the hdl/ files are compiled first
`timescale 1ns/100ps
module tb;
    logic core_clk = 1'b0, reset_n = 1'b0, wr = 1'b0, rd = 1'b0, link_up = 1'b1, fail_mode = 1'b0;
    logic net_rvalid = 1'b0, net_done = 1'b0, net_fail = 1'b0, irq, net_req;
    logic [9:0] addr = 10'h000;
    logic [15:0] wr_data = 16'h0000, net_rdata = 16'h0000, rd_data, net_addr, net_count, v;
    logic [7:0] net_access, net_attr;
    logic [6:0] net_station;
    logic eng_busy;
    int fails = 0, tests_run = 0;
    // Rows: good, codes, station, start, count
    localparam logic [64:0] ROWS [20] = '{65'h1_0004_0001_0100_0003, 65'h1_2004_0040_0000_0001,
        65'h1_2104_0002_0000_0002, 65'h1_2204_0003_0000_0002, 65'h1_2404_0001_0000_0002,
        65'h1_6304_0001_0000_0002, 65'h1_6404_0001_0000_01E0, 65'h1_0105_0001_0010_0002,
        65'h1_0205_0001_0000_0001, 65'h1_0305_0001_0020_0001, 65'h1_0405_0001_0000_0002,
        65'h1_2405_0001_0000_0001, 65'h1_4305_0001_0000_0001, 65'h1_4405_0001_0000_0001,
        65'h0_2005_0001_0000_0002, 65'h0_2003_0001_0000_0002, 65'h0_2004_0041_0000_0002,
        65'h0_2004_0001_0000_0000, 65'h0_2004_0001_0000_01E1, 65'h0_0105_0001_0008_0002};
    always #5 core_clk = ~core_clk;
    trq_if u_trq_if();
    trq_requester #(.SCAN_CYCLES(20)) u_trq_requester (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .LINK(u_trq_if), .ADDR(addr), .WR_DATA(wr_data), .WR(wr), .RD(rd), .RD_DATA(rd_data), .IRQ(irq));
    trq_engine u_trq_engine (.CORE_CLK(core_clk), .RESET_N(reset_n), .LINK(u_trq_if), .LINK_UP(link_up),
        .NET_REQ(net_req), .NET_STATION(net_station), .NET_ACCESS(net_access), .NET_ATTR(net_attr),
        .NET_ADDR(net_addr), .NET_COUNT(net_count), .NET_RVALID(net_rvalid), .NET_RDATA(net_rdata),
        .NET_DONE(net_done), .NET_FAIL(net_fail), .BUSY(eng_busy));
    trq_checker #(.IO_BASE(16'h0000)) u_trq_checker (.CORE_CLK(core_clk), .RESET_N(reset_n),
        .start(u_trq_if.start), .io_base(u_trq_if.io_base), .scan_end(u_trq_if.scan_end),
        .done(u_trq_if.done), .done_err(u_trq_if.done_err), .busy(u_trq_if.busy));
    // Remote station: words start+i, then end of fetch; data line toggles when idle
    always
    begin
        @(posedge core_clk);
        if (net_req)
        begin
            repeat (3) @(posedge core_clk);
            for (int i = 0; i < net_count; i++)
            begin
                net_rvalid <= 1'b1;
                net_rdata <= net_addr + 16'(i);
                @(posedge core_clk);
            end
            net_rvalid <= 1'b0;
            net_done <= 1'b1;
            net_fail <= fail_mode;
            @(posedge core_clk);
            net_done <= 1'b0;
            net_fail <= 1'b0;
        end
        net_rdata <= ~net_rdata;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            fails++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [9:0] a, input logic [15:0] d);
        addr <= a;
        wr_data <= d;
        wr <= 1'b1;
        @(posedge core_clk);
        wr <= 1'b0;
        @(posedge core_clk);
    endtask
    task automatic rd_reg(input logic [9:0] a, output logic [15:0] d);
        addr <= a;
        rd <= 1'b1;
        @(posedge core_clk);
        rd <= 1'b0;
        @(posedge core_clk);
        d = rd_data;
    endtask
    // Loads a control block, starts it (twice if asked) and waits for the end
    task automatic run(input logic [63:0] f, input logic twice);
        wr_reg(10'h001, f[47:32]);
        wr_reg(10'h002, f[63:48]);
        wr_reg(10'h003, f[31:16]);
        wr_reg(10'h004, f[15:0]);
        wr_reg(10'h008, 16'h0007);
        wr_reg(10'h000, 16'h0001);
        if (twice)
            wr_reg(10'h000, 16'h0001);
        for (int n = 0; n < 2000 && !(irq === 1'b1 && u_trq_if.busy === 1'b0); n++)
            @(posedge core_clk);
    endtask
    task automatic wrap_up;
        $display("tests_run=%0d fails=%0d", tests_run, fails);
        if (fails == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial
    begin
        #500000;
        fails++;
        wrap_up();
    end
    initial
    begin
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        wr_reg(10'h009, 16'h0007);
        for (int r = 0; r < 20; r++)
        begin
            run(ROWS[r][63:0], 1'b0);
            rd_reg(10'h007, v);
            chk(v, ROWS[r][64] ? 16'h0001 : 16'h0004);
            if (ROWS[r][64])
            begin
                rd_reg(10'h005, v);
                chk(v, 16'h0000);
                rd_reg(10'h200 + 10'(ROWS[r][15:0] - 16'h0001), v);
                chk(v, ROWS[r][31:16] + ROWS[r][15:0] - 16'h0001);
                chk({net_access, net_attr}, ROWS[r][63:48]);
                chk({9'h000, net_station}, ROWS[r][47:32]);
            end
            $display("row %0d end", r);
        end
        fail_mode <= 1'b1;
        run(64'h2004_0005_0000_0002, 1'b0);
        fail_mode <= 1'b0;
        rd_reg(10'h007, v);
        chk(v, 16'h0002);
        rd_reg(10'h005, v);
        chk(v, trq_pkg::ERR_REMOTE);
        run(64'h2004_0001_0000_0004, 1'b1);
        rd_reg(10'h007, v);
        chk(v, 16'h0005);
        wr_reg(10'h009, 16'h0000);
        @(posedge core_clk);
        chk({15'h0000, irq}, 16'h0000);
        wr_reg(10'h009, 16'h0007);
        @(posedge core_clk);
        chk({15'h0000, irq}, 16'h0001);
        $display("fail, overlap and mask tests end");
        link_up <= 1'b0;
        run(64'h2004_0001_0000_0002, 1'b0);
        rd_reg(10'h006, v);
        chk(v, 16'h0001);
        chk({15'h0000, eng_busy}, 16'h0001);
        rd_reg(10'h007, v);
        chk(v, 16'h0000);
        wr_reg(10'h000, 16'h0002);
        link_up <= 1'b1;
        repeat (4) @(posedge core_clk);
        rd_reg(10'h006, v);
        chk(v, 16'h0000);
        chk({15'h0000, eng_busy}, 16'h0000);
        reset_n <= 1'b0;
        repeat (6) @(posedge core_clk);
        reset_n <= 1'b1;
        @(posedge core_clk);
        rd_reg(10'h009, v);
        chk(v, 16'h0000);
        chk({15'h0000, irq}, 16'h0000);
        rd_reg(10'h0FF, v);
        chk(v, 16'h0000);
        $display("offline and reset tests end");
        wrap_up();
    end
endmodule
